// file: core/scc_pkg.sv
package scc_pkg;

  // ==========================================================================
  // Register numbers of the coprocessor transfer.
  localparam logic [3:0] REG_CONTROL    = 4'h1;
  localparam logic [3:0] REG_CACHEABLE  = 4'h2;
  localparam logic [3:0] REG_BUFFERABLE = 4'h3;
  localparam logic [3:0] REG_PERMISSION = 4'h5;
  localparam logic [3:0] REG_REGION     = 4'h6;
  localparam logic [3:0] REG_CACHE_OPS  = 4'h7;
  localparam logic [3:0] REG_LOCKDOWN   = 4'h9;
  localparam logic [3:0] REG_TEST       = 4'hf;

  // ==========================================================================
  // Secondary register field values for cache maintenance.
  localparam logic [3:0] CRM_FLUSH_I     = 4'h5;
  localparam logic [3:0] CRM_FLUSH_D     = 4'h6;
  localparam logic [3:0] CRM_CLEAN_D     = 4'ha;
  localparam logic [3:0] CRM_PREFETCH_I  = 4'hd;
  localparam logic [3:0] CRM_CLEANFLSH_D = 4'he;

  // ==========================================================================
  // Control word bit positions.
  localparam int CTL_PROT_EN   = 0;
  localparam int CTL_DCACHE_EN = 2;
  localparam int CTL_BIG_END   = 7;
  localparam int CTL_ICACHE_EN = 12;
  localparam int CTL_HIGH_VEC  = 13;
  localparam int CTL_BUS_CLK_N = 30;
  localparam int CTL_FREE_CLK  = 31;
  localparam logic [31:0] CTL_DEFINED_MASK = 32'hc000_3085;
  localparam logic [31:0] CTL_RESET        = 32'h0000_0000;

  // ==========================================================================
  // Vector bases, region fields, cache-op fields and sizes.
  localparam logic [31:0] VEC_BASE_LOW  = 32'h0000_0000;
  localparam logic [31:0] VEC_BASE_HIGH = 32'hffff_0000;
  localparam int          REGION_EN_BIT = 0;
  localparam logic [4:0]  SIZE_MIN_CODE = 5'h0b;
  localparam int          IDX_MSB       = 31;
  localparam int          IDX_LSB       = 26;
  localparam int          SEG_MSB       = 5;
  localparam int          SEG_LSB       = 4;
  localparam int          LOCK_LOAD_BIT = 31;
  localparam int          TEST_D_ROT    = 2;
  localparam int          TEST_I_ROT    = 3;

  // ==========================================================================
  // Clocking modes and access permission codes.
  typedef enum logic [1:0] {
    SCC_CLK_FAST_BUS = 2'b00,
    SCC_CLK_RESERVED = 2'b01,
    SCC_CLK_SYNC     = 2'b10,
    SCC_CLK_FREE_RUNNING_CLOCK_SELECT    = 2'b11
  } scc_clk_mode_t;

  typedef enum logic [1:0] {
    SCC_AP_NONE      = 2'b00,
    SCC_AP_PRIV_ONLY = 2'b01,
    SCC_AP_USER_RO   = 2'b10,
    SCC_AP_FULL      = 2'b11
  } scc_ap_t;

endpackage

// file: core/scc_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Control bit 0 enables protection, bit 2 data cache, bit 12 instruction cache.
// - Control bit 13 moves vector base from zero to 0xffff0000.
// - Control bits 31:30 select fast-bus, synchronous, reserved or asynchronous clocking.
// - Register 2 opcode_2 0 selects data cacheable, 1 instruction cacheable.
// - Cacheable registers hold eight area bits, reset to zero.
// - Register 3 holds eight data bufferable bits, reset to zero.
// - Register 5 holds two permission bits per area; opcode_2 picks data or instruction.
// - Permission codes: none, privileged only, user read-only, full.
// - Both permission registers reset to zero.
// - Region registers addressed by opcode_2 and secondary field c0 to c7.
// - Region word: base 31:12, unused 11:6, size 5:1, enable bit 0.
// - Reset clears only region enables; base and size stay undefined.
// - Region contents have no effect while protection is disabled.
// - Size code 01011 is 4KB, doubling to 11111 at 4GB; lower reserved.
// - Register 7 is write-only; c5/c6 flush instruction/data cache, whole or entry.
// - Register 7 c10 cleans, c14 cleans and flushes, c13 prefetches; opcode_2 1.
// - Entry operations take index from bits 31:26 and segment from 5:4.
// - Prefetch takes address bits 31:6 and segment from bits 5:4.
// - Register 9 holds data and instruction lockdown words, reset to zero.
// - A lockdown index covers all four segments at once.
// - Test register bits switch each cache to pseudo round-robin; reset zero.
module scc_regs
(
  // Clock and reset.
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // Coprocessor register transfer.
  input  wire logic        coproc_write_transfer_i,
  input  wire logic        coproc_read_transfer_i,
  input  wire logic [3:0]  reg_num_i,
  input  wire logic [3:0]  secondary_reg_field_i,
  input  wire logic [2:0]  opcode2_i,
  input  wire logic [31:0] wdata_i,
  output logic      [31:0] rdata_o,
  output logic             rvalid_o,
  // Control outputs.
  output logic             prot_en_o,
  output logic             dcache_en_o,
  output logic             icache_en_o,
  output logic             big_endian_o,
  output logic      [31:0] vector_base_o,
  output logic      [1:0]  clock_mode_o,
  // Area attributes.
  output logic      [7:0]  data_cacheable_o,
  output logic      [7:0]  instr_cacheable_o,
  output logic      [7:0]  data_bufferable_o,
  output logic      [15:0] data_perm_o,
  output logic      [15:0] instr_perm_o,
  output logic      [7:0]  data_region_en_o,
  output logic      [7:0]  instr_region_en_o,
  // Lockdown and test.
  output logic      [31:0] data_lockdown_o,
  output logic      [31:0] instr_lockdown_o,
  output logic             data_cache_rotate_test_o,
  output logic             instr_cache_rotate_test_o,
  // Cache maintenance pulses.
  output logic             flush_icache_o,
  output logic             flush_dcache_o,
  output logic             flush_ientry_o,
  output logic             flush_dentry_o,
  output logic             clean_dentry_o,
  output logic             clean_flush_dentry_o,
  output logic             prefetch_iline_o,
  output logic      [5:0]  op_index_o,
  output logic      [1:0]  op_segment_o,
  output logic      [25:0] op_address_o
);

  // ==========================================================================
  // Transfer decode.
  function automatic logic hit(input logic [3:0] r, input logic [3:0] want);
    hit = (r == want);
  endfunction

  logic  sel_d;
  logic  sel_i;
  logic  crm0;
  logic  wr_ctl;
  logic  wr_cache;
  logic  wr_buf;
  logic  wr_perm;
  logic  wr_region;
  logic  wr_op;
  logic  wr_lock;
  logic  wr_test;
  logic  entry_op;
  assign sel_d     = (opcode2_i == 3'h0);
  assign sel_i     = (opcode2_i == 3'h1);
  assign crm0      = (secondary_reg_field_i == 4'h0);
  assign wr_ctl    = coproc_write_transfer_i && hit(reg_num_i, scc_pkg::REG_CONTROL);
  assign wr_cache  = coproc_write_transfer_i && hit(reg_num_i, scc_pkg::REG_CACHEABLE) && crm0;
  assign wr_buf    = coproc_write_transfer_i && hit(reg_num_i, scc_pkg::REG_BUFFERABLE) && crm0;
  assign wr_perm   = coproc_write_transfer_i && hit(reg_num_i, scc_pkg::REG_PERMISSION) && crm0;
  assign wr_region = coproc_write_transfer_i && hit(reg_num_i, scc_pkg::REG_REGION)
                     && !secondary_reg_field_i[3];
  assign wr_op     = coproc_write_transfer_i && hit(reg_num_i, scc_pkg::REG_CACHE_OPS);
  assign wr_lock   = coproc_write_transfer_i && hit(reg_num_i, scc_pkg::REG_LOCKDOWN) && crm0;
  assign wr_test   = coproc_write_transfer_i && hit(reg_num_i, scc_pkg::REG_TEST);
  assign entry_op  = wr_op && sel_i;

  // ==========================================================================
  // Register state.
  logic [31:0] ctl_q;
  logic [7:0]  dcach_q;
  logic [7:0]  icach_q;
  logic [7:0]  dbuf_q;
  logic [15:0] dperm_q;
  logic [15:0] iperm_q;
  logic [31:0] dlock_q;
  logic [31:0] ilock_q;
  logic [1:0]  test_q;
  logic [31:1] dreg_q [8];
  logic [31:1] ireg_q [8];
  logic [7:0]  den_q;
  logic [7:0]  ien_q;
  logic [2:0]  rix;
  assign rix = secondary_reg_field_i[2:0];

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      ctl_q   <= scc_pkg::CTL_RESET;
      dcach_q <= 8'h00;
      icach_q <= 8'h00;
      dbuf_q  <= 8'h00;
      dperm_q <= 16'h0000;
      iperm_q <= 16'h0000;
      dlock_q <= 32'h0000_0000;
      ilock_q <= 32'h0000_0000;
      test_q  <= 2'h0;
      den_q   <= 8'h00;
      ien_q   <= 8'h00;
    end
    else
    begin
      if (wr_ctl) ctl_q <= wdata_i & scc_pkg::CTL_DEFINED_MASK;
      if (wr_cache && sel_d) dcach_q <= wdata_i[7:0];
      if (wr_cache && sel_i) icach_q <= wdata_i[7:0];
      if (wr_buf) dbuf_q <= wdata_i[7:0];
      if (wr_perm && sel_d) dperm_q <= wdata_i[15:0];
      if (wr_perm && sel_i) iperm_q <= wdata_i[15:0];
      if (wr_lock && sel_d) dlock_q <= wdata_i;
      if (wr_lock && sel_i) ilock_q <= wdata_i;
      if (wr_test) test_q <= {wdata_i[scc_pkg::TEST_I_ROT], wdata_i[scc_pkg::TEST_D_ROT]};
      if (wr_region && sel_d) den_q[rix] <= wdata_i[scc_pkg::REGION_EN_BIT];
      if (wr_region && sel_i) ien_q[rix] <= wdata_i[scc_pkg::REGION_EN_BIT];
    end
  end

  // Base and size fields carry no reset, as they are undefined after reset.
  always_ff @(posedge sys_clk_i)
  begin
    if (wr_region && sel_d) dreg_q[rix] <= wdata_i[31:1];
    if (wr_region && sel_i) ireg_q[rix] <= wdata_i[31:1];
  end

  // ==========================================================================
  // Read return.
  logic [31:0] rd_d;
  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (reg_num_i)
      scc_pkg::REG_CONTROL:    rd_d = ctl_q;
      scc_pkg::REG_CACHEABLE:  rd_d = {24'h0, sel_i ? icach_q : dcach_q};
      scc_pkg::REG_BUFFERABLE: rd_d = {24'h0, dbuf_q};
      scc_pkg::REG_PERMISSION: rd_d = {16'h0, sel_i ? iperm_q : dperm_q};
      scc_pkg::REG_REGION:     rd_d = sel_i ? {ireg_q[rix], ien_q[rix]}
                                            : {dreg_q[rix], den_q[rix]};
      scc_pkg::REG_LOCKDOWN:   rd_d = sel_i ? ilock_q : dlock_q;
      scc_pkg::REG_TEST:       rd_d = {28'h0, test_q, 2'h0};
      default:                 rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      rdata_o  <= 32'h0000_0000;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= coproc_read_transfer_i;
      if (coproc_read_transfer_i) rdata_o <= rd_d;
    end
  end

  // ==========================================================================
  // Registered control and attribute outputs.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      prot_en_o         <= 1'b0;
      dcache_en_o       <= 1'b0;
      icache_en_o       <= 1'b0;
      big_endian_o      <= 1'b0;
      vector_base_o     <= scc_pkg::VEC_BASE_LOW;
      clock_mode_o      <= scc_pkg::SCC_CLK_FAST_BUS;
      data_region_en_o  <= 8'h00;
      instr_region_en_o <= 8'h00;
    end
    else
    begin
      prot_en_o     <= ctl_q[scc_pkg::CTL_PROT_EN];
      dcache_en_o   <= ctl_q[scc_pkg::CTL_DCACHE_EN];
      icache_en_o   <= ctl_q[scc_pkg::CTL_ICACHE_EN];
      big_endian_o  <= ctl_q[scc_pkg::CTL_BIG_END];
      vector_base_o <= ctl_q[scc_pkg::CTL_HIGH_VEC] ? scc_pkg::VEC_BASE_HIGH
                                                    : scc_pkg::VEC_BASE_LOW;
      clock_mode_o  <= {ctl_q[scc_pkg::CTL_BUS_CLK_N], ctl_q[scc_pkg::CTL_FREE_CLK]};
      data_region_en_o  <= ctl_q[scc_pkg::CTL_PROT_EN] ? den_q : 8'h00;
      instr_region_en_o <= ctl_q[scc_pkg::CTL_PROT_EN] ? ien_q : 8'h00;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    data_cacheable_o          <= dcach_q;
    instr_cacheable_o         <= icach_q;
    data_bufferable_o         <= dbuf_q;
    data_perm_o               <= dperm_q;
    instr_perm_o              <= iperm_q;
    data_lockdown_o           <= dlock_q;
    instr_lockdown_o          <= ilock_q;
    data_cache_rotate_test_o  <= test_q[0];
    instr_cache_rotate_test_o <= test_q[1];
  end

  // ==========================================================================
  // Cache maintenance pulses, one cycle after the write.
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      flush_icache_o       <= 1'b0;
      flush_dcache_o       <= 1'b0;
      flush_ientry_o       <= 1'b0;
      flush_dentry_o       <= 1'b0;
      clean_dentry_o       <= 1'b0;
      clean_flush_dentry_o <= 1'b0;
      prefetch_iline_o     <= 1'b0;
      op_index_o           <= 6'h00;
      op_segment_o         <= 2'h0;
      op_address_o         <= 26'h000_0000;
    end
    else
    begin
      flush_icache_o <= wr_op && sel_d && hit(secondary_reg_field_i, scc_pkg::CRM_FLUSH_I);
      flush_dcache_o <= wr_op && sel_d && hit(secondary_reg_field_i, scc_pkg::CRM_FLUSH_D);
      flush_ientry_o <= entry_op && hit(secondary_reg_field_i, scc_pkg::CRM_FLUSH_I);
      flush_dentry_o <= entry_op && hit(secondary_reg_field_i, scc_pkg::CRM_FLUSH_D);
      clean_dentry_o <= entry_op && hit(secondary_reg_field_i, scc_pkg::CRM_CLEAN_D);
      clean_flush_dentry_o <= entry_op && hit(secondary_reg_field_i, scc_pkg::CRM_CLEANFLSH_D);
      prefetch_iline_o <= entry_op && hit(secondary_reg_field_i, scc_pkg::CRM_PREFETCH_I);
      if (wr_op)
      begin
        op_index_o   <= wdata_i[scc_pkg::IDX_MSB:scc_pkg::IDX_LSB];
        op_segment_o <= wdata_i[scc_pkg::SEG_MSB:scc_pkg::SEG_LSB];
        op_address_o <= wdata_i[31:6];
      end
    end
  end

  // ==========================================================================
  // Checks.
  // A control write and the quiet cycle over which the derived levels settle.
  sequence ctl_wr_settle;
    wr_ctl ##1 !wr_ctl;
  endsequence

  // An instruction cacheable write, a cycle without a write, then its readback.
  sequence icache_wr_then_rd;
    (wr_cache && sel_i) ##1 !coproc_write_transfer_i ##1 (coproc_read_transfer_i
      && reg_num_i == scc_pkg::REG_CACHEABLE && sel_i && !coproc_write_transfer_i);
  endsequence

  AST_VEC: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    wr_ctl ##2 !wr_ctl[*1] |-> vector_base_o ==
      ($past(wdata_i[scc_pkg::CTL_HIGH_VEC], 2) ? scc_pkg::VEC_BASE_HIGH : scc_pkg::VEC_BASE_LOW))
    else $error("vector base does not follow control bit");
  AST_PROT_GATE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !prot_en_o |-> data_region_en_o == 8'h00 && instr_region_en_o == 8'h00)
    else $error("region enabled while protection is off");
  AST_FLUSH_I: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (wr_op && sel_d && secondary_reg_field_i == scc_pkg::CRM_FLUSH_I) |=> flush_icache_o)
    else $error("instruction flush pulse missing");
  AST_CLEAN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clean_dentry_o |-> $past(wr_op && sel_i) && !clean_flush_dentry_o)
    else $error("clean pulse without its write");
  AST_IDX: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    wr_op |=> op_index_o == $past(wdata_i[31:26]) && op_segment_o == $past(wdata_i[5:4]))
    else $error("index or segment not captured");
  AST_CACHE_RD: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    icache_wr_then_rd |=> rdata_o[7:0] == $past(wdata_i[7:0], 3))
    else $error("instruction cacheable readback wrong");
  AST_PERM_RST: assert property (@(posedge sys_clk_i)
    $past(reset_i) |-> dperm_q == 16'h0000 && iperm_q == 16'h0000)
    else $error("permissions not cleared by reset");
  AST_CLKMODE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ctl_wr_settle |=> clock_mode_o == {$past(wdata_i[30], 2), $past(wdata_i[31], 2)})
    else $error("clock mode does not follow control bits");
  AST_RVALID: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    coproc_read_transfer_i |=> rvalid_o)
    else $error("read answer missing");
  AST_ENDIAN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ctl_wr_settle |=> big_endian_o == $past(wdata_i[7], 2))
    else $error("endianness does not follow control bit");
  AST_CTL_EN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ctl_wr_settle |=> prot_en_o == $past(wdata_i[0], 2)
      && dcache_en_o == $past(wdata_i[2], 2) && icache_en_o == $past(wdata_i[12], 2))
    else $error("enable outputs do not follow control bits");
  AST_RST_OUT: assert property (@(posedge sys_clk_i)
    $past(reset_i) |-> vector_base_o == scc_pkg::VEC_BASE_LOW && !big_endian_o
      && clock_mode_o == 2'h0 && !rvalid_o)
    else $error("control outputs not cleared by reset");
  AST_DCACHEABLE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (wr_cache && sel_d) ##1 !(wr_cache && sel_d) |=> data_cacheable_o == $past(wdata_i[7:0], 2))
    else $error("data cacheable bits not applied");
  AST_DBUF: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    wr_buf ##1 !wr_buf |=> data_bufferable_o == $past(wdata_i[7:0], 2))
    else $error("bufferable bits not applied");
  AST_DPERM: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (wr_perm && sel_d) ##1 !(wr_perm && sel_d) |=> data_perm_o == $past(wdata_i[15:0], 2))
    else $error("data permissions not applied");
  AST_ILOCK: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (wr_lock && sel_i) ##1 !(wr_lock && sel_i) |=> instr_lockdown_o == $past(wdata_i, 2))
    else $error("instruction lockdown not applied");
  AST_TEST: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    wr_test ##1 !wr_test |=> {instr_cache_rotate_test_o, data_cache_rotate_test_o}
      == {$past(wdata_i[3], 2), $past(wdata_i[2], 2)})
    else $error("rotate test bits not applied");
  AST_PREFETCH: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    prefetch_iline_o |-> op_address_o == $past(wdata_i[31:6]))
    else $error("prefetch address not captured");
  AST_OPS_RD: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (coproc_read_transfer_i && reg_num_i == scc_pkg::REG_CACHE_OPS) |=> rdata_o == 32'h0)
    else $error("maintenance register read not zero");

endmodule

// file: tb/scc_core_model.sv
`timescale 1ns/1ps
// ============================================================================
// Processor core side: issues one register transfer at a time to the bank.
module scc_core_model
(
  // Clock.
  input  wire logic        clk_i,
  // Transfer towards the bank.
  output logic             wr_o,
  output logic             rd_o,
  output logic      [3:0]  rn_o,
  output logic      [3:0]  crm_o,
  output logic      [2:0]  op2_o,
  output logic      [31:0] wd_o,
  // Answer from the bank.
  input  wire logic [31:0] rdata_i,
  input  wire logic        rvalid_i
);
  initial
  begin
    {wr_o, rd_o, rn_o, crm_o, op2_o, wd_o} = '0;
  end

  // Fields not qualified by a strobe show the inverse of their last value.
  task automatic drop;
    begin
      {rn_o, crm_o, op2_o, wd_o} = ~{rn_o, crm_o, op2_o, wd_o};
    end
  endtask

  task automatic wr(input logic [3:0] r, input logic [3:0] c, input logic [2:0] o,
                    input logic [31:0] d);
    begin
      @(negedge clk_i);
      rn_o = r;
      crm_o = c;
      op2_o = (r == scc_pkg::REG_BUFFERABLE) ? 3'h0 : o;
      wd_o = d;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      drop();
    end
  endtask

  // The answer is due one cycle after the strobe, so it is taken there.
  task automatic rd(input logic [3:0] r, input logic [3:0] c, input logic [2:0] o,
                    output logic [31:0] d, output logic ok);
    begin
      @(negedge clk_i);
      rn_o = r;
      crm_o = c;
      op2_o = o;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      drop();
      ok = (rvalid_i === 1'b1);
      d = rdata_i;
    end
  endtask
endmodule

// file: tb/scc_regs_tb_top.sv
`timescale 1ns/1ps
// ============================================================================
// Bench for the system control register bank.
module scc_regs_tb_top;
  logic        sys_clk, reset, wr_s, rd_s, rvalid, prot, dc, ic, be, drt, irt;
  logic [3:0]  rn, secondary_reg_field;
  logic [2:0]  op2;
  logic [31:0] wd, rdata, vb, dlk, ilk;
  logic [1:0]  cm, seg;
  logic [7:0]  dca, ica, dbu, dre, ire;
  logic [15:0] dpe, ipe;
  logic [6:0]  pls;
  logic [5:0]  idx;
  logic [25:0] adr;
  int          bad_count = 0;
  int          total_checks = 0;

  scc_core_model scc_core_model_i (.clk_i(sys_clk), .wr_o(wr_s), .rd_o(rd_s), .rn_o(rn),
    .crm_o(secondary_reg_field), .op2_o(op2), .wd_o(wd), .rdata_i(rdata), .rvalid_i(rvalid));

  scc_regs scc_regs_i (.sys_clk_i(sys_clk), .reset_i(reset), .coproc_write_transfer_i(wr_s),
    .coproc_read_transfer_i(rd_s), .reg_num_i(rn), .secondary_reg_field_i(secondary_reg_field),
    .opcode2_i(op2), .wdata_i(wd), .rdata_o(rdata), .rvalid_o(rvalid), .prot_en_o(prot),
    .dcache_en_o(dc), .icache_en_o(ic), .big_endian_o(be), .vector_base_o(vb),
    .clock_mode_o(cm), .data_cacheable_o(dca), .instr_cacheable_o(ica),
    .data_bufferable_o(dbu), .data_perm_o(dpe), .instr_perm_o(ipe), .data_region_en_o(dre),
    .instr_region_en_o(ire), .data_lockdown_o(dlk), .instr_lockdown_o(ilk),
    .data_cache_rotate_test_o(drt), .instr_cache_rotate_test_o(irt),
    .flush_icache_o(pls[0]), .flush_dcache_o(pls[1]), .flush_ientry_o(pls[2]),
    .flush_dentry_o(pls[3]), .clean_dentry_o(pls[4]), .clean_flush_dentry_o(pls[5]),
    .prefetch_iline_o(pls[6]), .op_index_o(idx), .op_segment_o(seg), .op_address_o(adr));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // Shared checks and transfers.
  task automatic report_and_stop;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    begin
      total_checks++;
      if (g !== e)
      begin
        bad_count++;
        $display("CHECK FAILED %s expected %h seen %h", w, e, g);
      end
    end
  endtask

  task automatic rdchk(input string w, input logic [3:0] r, input logic [3:0] c,
                       input logic [2:0] o, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    logic        ok;
    begin
      scc_core_model_i.rd(r, c, o, d, ok);
      if (!ok)
      begin
        bad_count++;
        $display("CHECK FAILED %s answer expected 1 seen 0", w);
        report_and_stop();
      end
      chk(w, e, d & m);
    end
  endtask

  // Levels derived from a register need one more edge than the register.
  task automatic wrs(input logic [3:0] r, input logic [3:0] c, input logic [2:0] o,
                     input logic [31:0] d);
    begin
      scc_core_model_i.wr(r, c, o, d);
      @(negedge sys_clk);
    end
  endtask

  function automatic logic [31:0] rword(int i, logic en);
    return {20'((i + 1) * 2), 6'h0, 5'h0c, en};
  endfunction

  // ==========================================================================
  // Scenarios.
  task automatic t_reset;
    logic [3:0] regs [8];
    begin
      regs = '{scc_pkg::REG_CONTROL, scc_pkg::REG_CACHEABLE, scc_pkg::REG_CACHEABLE,
               scc_pkg::REG_BUFFERABLE, scc_pkg::REG_PERMISSION, scc_pkg::REG_PERMISSION,
               scc_pkg::REG_LOCKDOWN, scc_pkg::REG_LOCKDOWN};
      chk("vector base", scc_pkg::VEC_BASE_LOW, vb);
      chk("flags", 32'h0, {24'h0, prot, dc, ic, be, cm, drt, irt});
      chk("attrs", 32'h0, {dca, ica, dbu, dre | ire});
      chk("perms", 32'h0, {dpe, ipe});
      for (int k = 0; k < 8; k++)
        rdchk("reset read", regs[k], 4'h0, 3'(k % 2 == 0 && k > 1), 32'h0, '1);
      rdchk("region enable", scc_pkg::REG_REGION, 4'h3, 3'h0, 32'h0, 32'h1);
    end
  endtask

  task automatic t_control;
    begin
      for (int m = 0; m < 4; m++)
      begin
        wrs(scc_pkg::REG_CONTROL, 4'h0, 3'h0, {m[0], m[1], 30'h0});
        chk("clock mode", 32'(m), {30'h0, cm});
      end
      wrs(scc_pkg::REG_CONTROL, 4'h0, 3'h0, 32'hffff_ffff);
      chk("flags all", 32'hf, {28'h0, prot, dc, ic, be});
      chk("vector high", scc_pkg::VEC_BASE_HIGH, vb);
      rdchk("control", scc_pkg::REG_CONTROL, 4'h0, 3'h0, 32'hc000_3085, '1);
      wrs(scc_pkg::REG_CONTROL, 4'h0, 3'h0, 32'h0000_1080);
      chk("flags mixed", 32'h3, {28'h0, prot, dc, ic, be});
      chk("vector low", scc_pkg::VEC_BASE_LOW, vb);
    end
  endtask

  task automatic t_attrs;
    scc_pkg::scc_ap_t ap [4];
    begin
      ap = '{scc_pkg::SCC_AP_NONE, scc_pkg::SCC_AP_PRIV_ONLY, scc_pkg::SCC_AP_USER_RO,
             scc_pkg::SCC_AP_FULL};
      scc_core_model_i.wr(scc_pkg::REG_CACHEABLE, 4'h0, 3'h0, 32'h0000_00a5);
      scc_core_model_i.wr(scc_pkg::REG_CACHEABLE, 4'h0, 3'h1, 32'h0000_005a);
      rdchk("i cacheable new", scc_pkg::REG_CACHEABLE, 4'h0, 3'h1, 32'h5a, '1);
      scc_core_model_i.wr(scc_pkg::REG_CACHEABLE, 4'h1, 3'h0, 32'h0000_00ff);
      scc_core_model_i.wr(scc_pkg::REG_BUFFERABLE, 4'h0, 3'h1, 32'h0000_003c);
      scc_core_model_i.wr(scc_pkg::REG_PERMISSION, 4'h0, 3'h0, 32'h0000_1be4);
      wrs(scc_pkg::REG_PERMISSION, 4'h0, 3'h1, 32'h0000_e41b);
      chk("area bits", 32'ha55a_3c00, {dca, ica, dbu, 8'h0});
      chk("perm bits", 32'h1be4_e41b, {dpe, ipe});
      for (int n = 0; n < 4; n++)
        chk("perm code", 32'(ap[n]), 32'(dpe[2 * n +: 2]));
      rdchk("d cacheable", scc_pkg::REG_CACHEABLE, 4'h0, 3'h0, 32'ha5, '1);
      rdchk("i cacheable", scc_pkg::REG_CACHEABLE, 4'h0, 3'h1, 32'h5a, '1);
      rdchk("bufferable", scc_pkg::REG_BUFFERABLE, 4'h0, 3'h0, 32'h3c, '1);
      rdchk("i perm", scc_pkg::REG_PERMISSION, 4'h0, 3'h1, 32'he41b, '1);
    end
  endtask

  task automatic t_regions;
    begin
      wrs(scc_pkg::REG_CONTROL, 4'h0, 3'h0, 32'h0);
      for (int i = 0; i < 8; i++)
      begin
        scc_core_model_i.wr(scc_pkg::REG_REGION, 4'(i), 3'h0, rword(i, 1'(i % 2)));
        scc_core_model_i.wr(scc_pkg::REG_REGION, 4'(i), 3'h1, rword(i, i < 4));
      end
      @(negedge sys_clk);
      chk("regions off", 32'h0, {16'h0, dre, ire});
      for (int i = 0; i < 8; i++)
      begin
        rdchk("d region", scc_pkg::REG_REGION, 4'(i), 3'h0, rword(i, 1'(i % 2)), '1);
        rdchk("i region", scc_pkg::REG_REGION, 4'(i), 3'h1, rword(i, i < 4), '1);
      end
      wrs(scc_pkg::REG_CONTROL, 4'h0, 3'h0, 32'h1);
      chk("regions on", 32'haa0f, {16'h0, dre, ire});
    end
  endtask

  task automatic t_cache_ops;
    logic [3:0]  cs [7];
    logic [31:0] d;
    begin
      cs = '{4'h5, 4'h6, 4'h5, 4'h6, 4'ha, 4'he, 4'hd};
      for (int k = 0; k < 7; k++)
      begin
        d = {6'(40 + k), (k == 6) ? 20'hbcde5 : 20'h0, 2'(k), 4'h0};
        scc_core_model_i.wr(scc_pkg::REG_CACHE_OPS, cs[k], 3'(k > 1), d);
        chk("op pulse", 32'(1 << k), 32'(pls));
        chk("op fields", {26'(40 + k), 2'(k), 4'h0}, {26'(idx), seg, 4'h0});
        if (k == 6)
          chk("prefetch address", d[31:6], 32'(adr));
        @(negedge sys_clk);
        chk("pulse ends", 32'h0, 32'(pls));
      end
      scc_core_model_i.wr(scc_pkg::REG_CACHE_OPS, 4'h5, 3'h2, 32'h0);
      chk("bad opcode", 32'h0, 32'(pls));
      rdchk("ops read", scc_pkg::REG_CACHE_OPS, 4'h5, 3'h0, 32'h0, '1);
      rdchk("reserved read", 4'h4, 4'h0, 3'h0, 32'h0, '1);
    end
  endtask

  task automatic t_lock_test;
    begin
      scc_core_model_i.wr(scc_pkg::REG_LOCKDOWN, 4'h0, 3'h0, 32'h8000_0015);
      wrs(scc_pkg::REG_LOCKDOWN, 4'h0, 3'h1, 32'h0000_0031);
      chk("d lock", 32'h8000_0015, dlk);
      chk("i lock", 32'h0000_0031, ilk);
      rdchk("d lock rd", scc_pkg::REG_LOCKDOWN, 4'h0, 3'h0, 32'h8000_0015, '1);
      wrs(scc_pkg::REG_TEST, 4'h0, 3'h0, 32'h4);
      chk("d rotate", 32'h2, {30'h0, drt, irt});
      wrs(scc_pkg::REG_TEST, 4'h0, 3'h0, 32'h8);
      chk("i rotate", 32'h1, {30'h0, drt, irt});
    end
  endtask

  initial
  begin
    reset = 1'b1;
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    t_reset();
    t_control();
    t_attrs();
    t_regions();
    t_cache_ops();
    t_lock_test();
    report_and_stop();
  end
endmodule
